//--- rtl/fpc_pkg.sv
// Constants, field layouts and decode helpers for the coprocessor issue block.
// Assumes one shared system clock with the integer unit and a synchronous reset.
package fpc_pkg;

  // Register map, byte addresses on the 8-bit register port
  localparam logic [7:0] REG_FSR       = 8'h00;  // Status and control
  localparam logic [7:0] REG_QADDR     = 8'h04;  // Queue head address
  localparam logic [7:0] REG_QINSTR    = 8'h08;  // Queue head instruction
  localparam logic [7:0] REG_QCTL      = 8'h0c;  // Queue control and count
  localparam int         REG_FREG_BIT  = 7;      // Set: operand register window
  localparam int         QCTL_CLEAR    = 0;      // Write one: empty the queue

  // Status and control field positions
  localparam int FSR_RND_LSB  = 30;  // Rounding mode [31:30]
  localparam int FSR_TEM_LSB  = 23;  // Trap enables [27:23]
  localparam int FSR_FTT_LSB  = 14;  // Trap type [16:14]
  localparam int FSR_QNE      = 13;  // Queue not empty
  localparam int FSR_FCC_LSB  = 10;  // Condition codes [11:10]
  localparam int FSR_AEXC_LSB = 5;   // Accrued exceptions [9:5]
  localparam int FSR_CEXC_LSB = 0;   // Current exceptions [4:0]
  localparam logic [31:0] FSR_RESET = 32'h0000_0000;
  localparam logic [2:0]  FTT_NONE  = 3'h0;
  localparam logic [2:0]  FTT_UNIMP = 3'h3;

  // Instruction encodings
  localparam logic [1:0] OP_ARITH   = 2'h2;
  localparam logic [1:0] OP_MEM     = 2'h3;
  localparam logic [5:0] OP3_FPOP1  = 6'h34;
  localparam logic [5:0] OP3_FPOP2  = 6'h35;
  localparam logic [5:0] OP3_LDF    = 6'h20;
  localparam logic [5:0] OP3_LDFSR  = 6'h21;
  localparam logic [5:0] OP3_STF    = 6'h24;
  localparam logic [5:0] OP3_STFSR  = 6'h25;
  localparam logic [8:0] OPF_MOVS   = 9'h001;
  localparam logic [8:0] OPF_MOVPR  = 9'h002;
  localparam logic [8:0] OPF_NEGS   = 9'h005;
  localparam logic [8:0] OPF_ABSS   = 9'h009;

  // Timing of one operate instruction in the queue head
  localparam int CLK_PERIOD_NS = 100;
  localparam int EXEC_TIME_NS  = 300;
  localparam int EXEC_CYCLES   = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUEUE_DEPTH   = 4;

  // Instruction class, one-hot
  typedef enum logic [3:0] {
    FPC_CL_NONE  = 4'b0001,
    FPC_CL_FP_OPERATE_INSTRUCTION  = 4'b0010,
    FPC_CL_LOAD  = 4'b0100,
    FPC_CL_STORE = 4'b1000
  } fpc_class_e;

  // Sort an instruction word into its class
  function automatic fpc_class_e fpc_classify(input logic [31:0] ins);
    logic [5:0] op3;
    op3 = ins[24:19];
    if (ins[31:30] == OP_ARITH && (op3 == OP3_FPOP1 || op3 == OP3_FPOP2))
      return FPC_CL_FP_OPERATE_INSTRUCTION;
    if (ins[31:30] == OP_MEM && (op3 == OP3_LDF || op3 == OP3_LDFSR))
      return FPC_CL_LOAD;
    if (ins[31:30] == OP_MEM && (op3 == OP3_STF || op3 == OP3_STFSR))
      return FPC_CL_STORE;
    return FPC_CL_NONE;
  endfunction

  // Load or store touching the status register instead of an operand
  function automatic logic fpc_is_fsr(input logic [31:0] ins);
    return ins[24:19] == OP3_LDFSR || ins[24:19] == OP3_STFSR;
  endfunction

  // One-hot mask of a register index
  function automatic logic [31:0] fpc_bit(input logic [4:0] idx);
    return 32'h0000_0001 << idx;
  endfunction

endpackage

//--- rtl/fpc_q_if.sv
// Interface between issue logic and the instruction queue.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface fpc_q_if #(parameter int DEPTH = 4);
  logic                       push;        // Enter one pair
  logic [31:0]                push_instr;  // Pair instruction
  logic [31:0]                push_addr;   // Pair address
  logic                       pop;         // Retire the head
  logic                       clear;       // Empty the queue
  logic [$clog2(DEPTH+1)-1:0] count;       // Entries held
  logic                       empty;       // No entry
  logic [31:0]                head_instr;  // Oldest instruction
  logic [31:0]                head_addr;   // Oldest address
  modport issue (output push, push_instr, push_addr, pop, clear,
                 input count, empty, head_instr, head_addr);
  modport store (input push, push_instr, push_addr, pop, clear,
                 output count, empty, head_instr, head_addr);
endinterface

//--- rtl/fpc_queue.sv
// Instruction/address queue for operate instructions under execution.
// Assumes the issue logic never pushes when full and never pops when empty.
`timescale 1ns/10ps
module fpc_queue #(
  parameter int DEPTH = 4
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Issue side
  fpc_q_if.store   q
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  // Whole queue state
  typedef struct packed {
    logic [DEPTH-1:0][31:0] instr;  // Instruction words
    logic [DEPTH-1:0][31:0] addr;   // Matching addresses
    logic [PW-1:0]          wptr;   // Next free slot
    logic [PW-1:0]          rptr;   // Oldest slot
    logic [CW-1:0]          cnt;    // Fill level
  } fpc_qstate_s;

  fpc_qstate_s st_reg;   // Registered state
  fpc_qstate_s st_next;  // Next state

  // Advance a ring pointer with wrap
  function automatic logic [PW-1:0] fpc_inc(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  // Push, pop and clear
  always_comb begin
    st_next = st_reg;
    if (q.clear) begin
      // Clear drops everything, including a same-cycle push
      st_next.wptr = '0;
      st_next.rptr = '0;
      st_next.cnt  = '0;
    end else begin
      // Faulting pair stays until retired or cleared
      if (q.push) begin
        st_next.instr[st_reg.wptr] = q.push_instr;
        st_next.addr[st_reg.wptr]  = q.push_addr;
        st_next.wptr               = fpc_inc(st_reg.wptr);
      end
      if (q.pop) begin
        st_next.rptr = fpc_inc(st_reg.rptr);
      end
      st_next.cnt = st_reg.cnt + CW'(q.push) - CW'(q.pop);
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // Head and level outputs
  assign q.count      = st_reg.cnt;
  assign q.empty      = (st_reg.cnt == '0);
  assign q.head_instr = st_reg.instr[st_reg.rptr];
  assign q.head_addr  = st_reg.addr[st_reg.rptr];
endmodule

//--- rtl/fpc_issue.sv
// Instruction capture, decode, issue and queue retirement of the coprocessor.
// Assumes the integer unit shares the clock, so its pins need no synchroniser.
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/10ps
module fpc_issue #(
  parameter int QDEPTH = fpc_pkg::QUEUE_DEPTH
) (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Shared buses
  input  wire logic [31:0] addr_bus,
  input  wire logic [31:0] data_in,
  output logic      [31:0] data_out,
  output logic             data_oe,
  // Integer unit handshake
  input  wire logic        inst_valid,
  input  wire logic        fp_launch_strobe_a,
  input  wire logic        fp_launch_strobe_b,
  output logic             coproc_pipeline_freeze,
  output logic             fp_exception_pending,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata
);
  localparam int CW = $clog2(QDEPTH + 1);
  localparam int XC = fpc_pkg::EXEC_CYCLES;

  // Whole block state
  typedef struct packed {
    logic [31:0]       a_d1;       // Address seen one cycle ago
    logic              fetch_pend; // Fetch-valid seen last cycle
    logic [31:0]       fetch_addr; // Address bound to pending fetch
    logic [31:0]       cur_instr;  // Newest stored pair
    logic [31:0]       cur_addr;
    logic [31:0]       prv_instr;  // Previous pair for deferred launch
    logic [31:0]       prv_addr;
    logic              e_v;        // Execute stage holds an instruction
    logic [31:0]       e_instr;
    logic [31:0]       e_addr;
    logic              w_v;        // Write stage holds an instruction
    logic [31:0]       w_instr;
    logic [31:0]       w_addr;
    logic [31:0]       ld_buf;     // Load buffer
    logic              ld_pend;    // Load buffer awaits writeback
    logic [4:0]        ld_rd;      // Load target
    logic              ld_fsr;     // Load targets status register
    logic [31:0]       st_buf;     // Store buffer
    logic [31:0]       busy;       // Destinations of queued operations
    logic [7:0]        cnt;        // Head execution counter
    logic              exc_stop;   // Head faulted, queue halted
    logic [31:0]       fp_status_control_reg;        // Status and control register
    logic [31:0][31:0] fregs;      // Operand register file
    logic [31:0]       rdata;      // Register port read data
  } fpc_state_s;

  fpc_state_s st_reg;   // Registered state
  fpc_state_s st_next;  // Next state

  fpc_q_if #(.DEPTH(QDEPTH)) qi ();

  // Queue of operate instructions under execution
  fpc_queue #(
    .DEPTH (QDEPTH)
  ) u_queue (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .q   (qi)
  );

  // Read an even-odd pair as one double operand
  function automatic logic [63:0] fpc_pair_rd(input logic [31:0][31:0] fr,
                                              input logic [4:0] idx);
    return {fr[{idx[4:1], 1'b0}], fr[{idx[4:1], 1'b1}]};
  endfunction

  // Registers that an instruction reads or writes
  function automatic logic [31:0] fpc_uses(input logic [31:0] ins);
    fpc_pkg::fpc_class_e c;
    c = fpc_pkg::fpc_classify(ins);
    if (c == fpc_pkg::FPC_CL_FP_OPERATE_INSTRUCTION)
      return fpc_pkg::fpc_bit(ins[18:14]) | fpc_pkg::fpc_bit(ins[4:0])
           | fpc_pkg::fpc_bit(ins[29:25]);
    if (c != fpc_pkg::FPC_CL_NONE && !fpc_pkg::fpc_is_fsr(ins))
      return fpc_pkg::fpc_bit(ins[29:25]);
    return 32'h0000_0000;
  endfunction

  // Control and datapath
  always_comb begin
    fpc_pkg::fpc_class_e e_cl;
    fpc_pkg::fpc_class_e w_cl;
    fpc_pkg::fpc_class_e h_cl;
    logic [31:0]         pend_mask;
    logic [CW:0]         level;
    logic                dep;
    logic                exc_set;
    logic [4:0]          h_rd;
    logic [8:0]          h_opf;
    logic [31:0]         h_src;
    e_cl          = fpc_pkg::fpc_classify(st_reg.e_instr);
    w_cl          = fpc_pkg::fpc_classify(st_reg.w_instr);
    h_cl          = fpc_pkg::fpc_classify(qi.head_instr);
    pend_mask     = st_reg.busy;
    level         = '0;
    dep           = 1'b0;
    exc_set       = 1'b0;
    h_rd          = qi.head_instr[29:25];
    h_opf         = qi.head_instr[13:5];
    h_src         = st_reg.fregs[qi.head_instr[4:0]];
    st_next       = st_reg;
    qi.push       = 1'b0;
    qi.push_instr = st_reg.w_instr;
    qi.push_addr  = st_reg.w_addr;
    qi.pop        = 1'b0;
    qi.clear      = 1'b0;

    // Software writes first, so hardware updates below take priority
    if (reg_wr) begin
      if (reg_addr[fpc_pkg::REG_FREG_BIT]) begin
        st_next.fregs[reg_addr[6:2]] = reg_wdata;
      end else if (reg_addr == fpc_pkg::REG_FSR) begin
        st_next.fp_status_control_reg = reg_wdata;
      end
    end

    // Queue head: count execution, then retire or fault
    if (!qi.empty && !st_reg.exc_stop && h_cl == fpc_pkg::FPC_CL_FP_OPERATE_INSTRUCTION) begin
      if (st_reg.cnt == 8'(XC - 1)) begin
        st_next.cnt = 8'h00;
        unique case (h_opf)
          fpc_pkg::OPF_MOVS: st_next.fregs[h_rd] = h_src;
          fpc_pkg::OPF_NEGS: st_next.fregs[h_rd] = {~h_src[31], h_src[30:0]};
          fpc_pkg::OPF_ABSS: st_next.fregs[h_rd] = {1'b0, h_src[30:0]};
          fpc_pkg::OPF_MOVPR: begin
            {st_next.fregs[{h_rd[4:1], 1'b0}], st_next.fregs[{h_rd[4:1], 1'b1}]} =
              fpc_pair_rd(st_reg.fregs, qi.head_instr[4:0]);
          end
          default: exc_set = 1'b1;
        endcase
        if (exc_set) begin
          // Fault: hold the pair at the head for the trap handler
          st_next.exc_stop = 1'b1;
          st_next.fp_status_control_reg[fpc_pkg::FSR_FTT_LSB +: 3] = fpc_pkg::FTT_UNIMP;
        end else begin
          st_next.busy = st_next.busy & ~fpc_pkg::fpc_bit(h_rd);
          if (h_opf == fpc_pkg::OPF_MOVPR) begin
            st_next.busy = st_next.busy & ~fpc_pkg::fpc_bit({h_rd[4:1], 1'b1})
                                        & ~fpc_pkg::fpc_bit({h_rd[4:1], 1'b0});
          end
          qi.pop = 1'b1;
        end
      end else begin
        st_next.cnt = st_reg.cnt + 8'h01;
      end
    end else if (!qi.empty && !st_reg.exc_stop) begin
      qi.pop = 1'b1;
    end

    // Dependency check on the instruction entering execute
    if (st_reg.w_v && w_cl != fpc_pkg::FPC_CL_NONE) begin
      pend_mask = pend_mask | fpc_uses(st_reg.w_instr);
    end
    if (st_reg.ld_pend && !st_reg.ld_fsr) begin
      pend_mask = pend_mask | fpc_pkg::fpc_bit(st_reg.ld_rd);
    end
    level = (CW+1)'(qi.count) + (CW+1)'(st_reg.w_v && w_cl == fpc_pkg::FPC_CL_FP_OPERATE_INSTRUCTION)
          - (CW+1)'(qi.pop);
    if (st_reg.e_v) begin
      dep = (fpc_uses(st_reg.e_instr) & pend_mask) != 32'h0000_0000;
      if (e_cl == fpc_pkg::FPC_CL_FP_OPERATE_INSTRUCTION && level >= (CW+1)'(QDEPTH)) begin
        dep = 1'b1;
      end
      if (fpc_pkg::fpc_is_fsr(st_reg.e_instr) && e_cl != fpc_pkg::FPC_CL_NONE
          && (level != '0 || st_reg.w_v)) begin
        dep = 1'b1;
      end
    end
    // Freeze drops the cycle the head pops for a slot, one cycle after the pop for an operand
    coproc_pipeline_freeze = st_reg.e_v && dep;

    // Load writeback from the load buffer
    if (st_reg.ld_pend) begin
      st_next.ld_pend = 1'b0;
      if (st_reg.ld_fsr) begin
        st_next.fp_status_control_reg = st_reg.ld_buf;
      end else begin
        st_next.fregs[st_reg.ld_rd] = st_reg.ld_buf;
      end
    end

    // Write stage: queue operate, capture load data, store drives bus
    if (st_reg.w_v) begin
      unique case (w_cl)
        fpc_pkg::FPC_CL_FP_OPERATE_INSTRUCTION: begin
          qi.push      = 1'b1;
          st_next.busy = st_next.busy | fpc_pkg::fpc_bit(st_reg.w_instr[29:25]);
          if (st_reg.w_instr[13:5] == fpc_pkg::OPF_MOVPR) begin
            st_next.busy = st_next.busy
                         | fpc_pkg::fpc_bit({st_reg.w_instr[29:26], 1'b0})
                         | fpc_pkg::fpc_bit({st_reg.w_instr[29:26], 1'b1});
          end
        end
        fpc_pkg::FPC_CL_LOAD: begin
          // Address and strobes come from the integer unit; only data here
          st_next.ld_buf  = data_in;
          st_next.ld_pend = 1'b1;
          st_next.ld_rd   = st_reg.w_instr[29:25];
          st_next.ld_fsr  = fpc_pkg::fpc_is_fsr(st_reg.w_instr);
        end
        default: begin
          // Store data leaves from the store buffer; nothing else to do
        end
      endcase
    end

    // Execute to write, and launch into execute, in lockstep
    if (coproc_pipeline_freeze) begin
      st_next.w_v = 1'b0;
    end else begin
      st_next.w_v     = st_reg.e_v;
      st_next.w_instr = st_reg.e_instr;
      st_next.w_addr  = st_reg.e_addr;
      if (st_reg.e_v && e_cl == fpc_pkg::FPC_CL_STORE) begin
        st_next.st_buf = fpc_pkg::fpc_is_fsr(st_reg.e_instr) ? st_reg.fp_status_control_reg
                       : st_reg.fregs[st_reg.e_instr[29:25]];
      end
      // Strobe sampled at the edge that starts execute
      st_next.e_v = fp_launch_strobe_a || fp_launch_strobe_b;
      if (fp_launch_strobe_a) begin
        st_next.e_instr = st_reg.cur_instr;
        st_next.e_addr  = st_reg.cur_addr;
      end else if (fp_launch_strobe_b) begin
        // Deferred launch picks the pair stored before the newest
        st_next.e_instr = st_reg.prv_instr;
        st_next.e_addr  = st_reg.prv_addr;
      end
    end

    // Fetch: address of cycle t, fetch-valid in t+1, word in t+2
    st_next.a_d1 = addr_bus;
    if (!coproc_pipeline_freeze) begin
      st_next.fetch_pend = inst_valid;
      if (inst_valid) begin
        st_next.fetch_addr = st_reg.a_d1;
      end
      if (st_reg.fetch_pend) begin
        // One pair per fetch; the pair stays until the next fetch
        st_next.prv_instr = st_reg.cur_instr;
        st_next.prv_addr  = st_reg.cur_addr;
        st_next.cur_instr = data_in;
        st_next.cur_addr  = st_reg.fetch_addr;
      end
    end else begin
      st_next.fetch_pend = 1'b0;
    end

    // Software empties the queue; a same-cycle fault wins
    if (reg_wr && reg_addr == fpc_pkg::REG_QCTL && reg_wdata[fpc_pkg::QCTL_CLEAR]
        && !exc_set) begin
      qi.clear         = 1'b1;
      qi.pop           = 1'b0;
      st_next.busy     = 32'h0000_0000;
      st_next.exc_stop = 1'b0;
      st_next.cnt      = 8'h00;
      st_next.fp_status_control_reg[fpc_pkg::FSR_FTT_LSB +: 3] = fpc_pkg::FTT_NONE;
    end

    // Queue state mirrored into the status register
    st_next.fp_status_control_reg[fpc_pkg::FSR_QNE] = !qi.empty;

    // Register reads, answered in the following cycle
    st_next.rdata = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr[fpc_pkg::REG_FREG_BIT]) begin
        st_next.rdata = st_reg.fregs[reg_addr[6:2]];
      end else begin
        unique case (reg_addr)
          fpc_pkg::REG_FSR:    st_next.rdata = st_reg.fp_status_control_reg;
          fpc_pkg::REG_QADDR:  st_next.rdata = qi.head_addr;
          fpc_pkg::REG_QINSTR: st_next.rdata = qi.head_instr;
          fpc_pkg::REG_QCTL:   st_next.rdata = 32'(qi.count);
          default:             st_next.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg     <= '0;
      st_reg.fp_status_control_reg <= fpc_pkg::FSR_RESET;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign data_out             = st_reg.st_buf;
  assign data_oe              = st_reg.w_v
                              && fpc_pkg::fpc_classify(st_reg.w_instr) == fpc_pkg::FPC_CL_STORE;
  assign fp_exception_pending = st_reg.exc_stop;
  assign reg_rdata            = st_reg.rdata;
endmodule

//--- tb/fpc_checker.sv
// Port-level assertions for the coprocessor issue block.
// Assumes ce is held high, so every edge is a working edge.
`timescale 1ns/10ps
module fpc_checker #(
  parameter int QDEPTH = 4
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Handshake and bus
  input wire logic        fp_launch_strobe_a,
  input wire logic        fp_launch_strobe_b,
  input wire logic        coproc_pipeline_freeze,
  input wire logic        fp_exception_pending,
  input wire logic        data_oe,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic go;   // Any launch strobe
  wire logic clr;  // Queue clear write
  assign go  = fp_launch_strobe_a || fp_launch_strobe_b;
  assign clr = reg_wr && reg_addr == fpc_pkg::REG_QCTL && reg_wdata[fpc_pkg::QCTL_CLEAR];
  // Read data shows only after a read
  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
  // Operand register returns what was written
  property p_freg_rw;
    reg_wr && reg_addr[7] ##1 reg_rd && reg_addr == $past(reg_addr) |=>
      reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_freg_rw: assert property (p_freg_rw) else $error("operand register lost data");
  // Store data goes out in the write stage
  property p_oe_launch;
    data_oe |-> $past(go, 2) || $past(coproc_pipeline_freeze, 2);
  endproperty
  a_oe_launch: assert property (p_oe_launch) else $error("bus driven off a store");
  // Freeze rises only as a launched instruction enters execute
  property p_freeze_cause;
    $rose(coproc_pipeline_freeze) |-> $past(go);
  endproperty
  a_freeze_cause: assert property (p_freeze_cause) else $error("freeze without launch");
  // Emptying the queue ends a freeze
  property p_freeze_release;
    clr && coproc_pipeline_freeze |=> !coproc_pipeline_freeze;
  endproperty
  a_freeze_release: assert property (p_freeze_release) else $error("freeze kept");
  // A fault stays until software clears the queue
  property p_exc_stick;
    fp_exception_pending && !clr |=> fp_exception_pending;
  endproperty
  a_exc_stick: assert property (p_exc_stick) else $error("fault dropped");
  // Status shows queue busy and trap type on a fault
  property p_exc_fsr;
    fp_exception_pending && reg_rd && reg_addr == fpc_pkg::REG_FSR |=>
      reg_rdata[fpc_pkg::FSR_QNE] && reg_rdata[16:14] == fpc_pkg::FTT_UNIMP;
  endproperty
  a_exc_fsr: assert property (p_exc_fsr) else $error("status misses fault");
  // Faulting entry is still counted in the queue
  property p_exc_queue;
    fp_exception_pending && reg_rd && reg_addr == fpc_pkg::REG_QCTL |=> reg_rdata != 32'h0;
  endproperty
  a_exc_queue: assert property (p_exc_queue) else $error("queue empty on fault");
  c_store: cover property (data_oe);
  c_freeze: cover property ($rose(coproc_pipeline_freeze));
  c_fault: cover property (fp_exception_pending);
endmodule
bind fpc_issue fpc_checker #(.QDEPTH(QDEPTH)) u_chk (.clk(clk), .rst(rst),
  .fp_launch_strobe_a(fp_launch_strobe_a), .fp_launch_strobe_b(fp_launch_strobe_b),
  .coproc_pipeline_freeze(coproc_pipeline_freeze), .fp_exception_pending(fp_exception_pending),
  .data_oe(data_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata));

//--- tb/fpc_iu_model.sv
// Integer unit model: fetches and launches on the shared buses.
// Assumes tasks are called just after a rising edge.
`timescale 1ns/10ps
module fpc_iu_model (
  // Clock
  input wire logic clk,
  // Buses and handshake
  output logic [31:0] addr_bus,
  output logic [31:0] data_drv,
  output logic        inst_valid,
  output logic        strobe_a,
  output logic        strobe_b,
  output logic        timed_out,
  input wire logic    freeze
);
  initial begin
    {addr_bus, data_drv} = 64'h0;
    {inst_valid, strobe_a, strobe_b, timed_out} = 4'h0;
  end
  // Address, fetch-valid one clock later, word after that
  task automatic fetch(input logic [31:0] a, input logic [31:0] i);
    addr_bus <= a;
    @(posedge clk);
    inst_valid <= 1'b1;
    addr_bus <= ~a;
    @(posedge clk);
    inst_valid <= 1'b0;
    data_drv <= i;
    @(posedge clk);
    data_drv <= ~i;
  endtask
  // One strobe in decode, held through freeze; load word in write stage
  task automatic launch(input logic sel_b, input logic [31:0] d);
    int k;
    k = 0;
    strobe_a <= !sel_b;
    strobe_b <= sel_b;
    @(negedge clk);
    while (freeze === 1'b1 && k < 60) begin
      @(negedge clk);
      k++;
    end
    timed_out <= (k == 60);
    @(posedge clk);
    strobe_a <= 1'b0;
    strobe_b <= 1'b0;
    @(posedge clk);
    data_drv <= d;
    @(posedge clk);
    data_drv <= ~d;
  endtask
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the coprocessor issue block.
// Assumes one 10 MHz clock; the integer unit model drives the buses.
`timescale 1ns/10ps
module tb_top;
  logic        clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, rv, last_st, d, iu_data, addr_bus, data_out, reg_rdata;
  logic        inst_valid, sa, sb, freeze, exc, data_oe, tmo;
  logic [31:0] exp_f [32];  // Operand register model
  int          n_mismatch = 0, checks = 0, n_oe = 0, i;
  wire logic [31:0] data_bus;
  assign data_bus = data_oe ? data_out : iu_data;
  always #50 clk = ~clk;
  // Log every store cycle on the bus
  always @(posedge clk) if (data_oe === 1'b1) begin
    n_oe++;
    last_st = data_out;
  end
  always @(posedge tmo) begin
    n_mismatch++;
    test_done();
  end
  fpc_iu_model u_iu (.clk(clk), .addr_bus(addr_bus), .data_drv(iu_data),
    .inst_valid(inst_valid), .strobe_a(sa), .strobe_b(sb), .timed_out(tmo), .freeze(freeze));
  fpc_issue DUT (.clk(clk), .rst(rst), .ce(1'b1), .addr_bus(addr_bus), .data_in(data_bus),
    .data_out(data_out), .data_oe(data_oe), .inst_valid(inst_valid),
    .fp_launch_strobe_a(sa), .fp_launch_strobe_b(sb), .coproc_pipeline_freeze(freeze),
    .fp_exception_pending(exc), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One-cycle register write and read
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  function automatic logic [31:0] fp_operate_instruction(input logic [8:0] f, input logic [4:0] r, s);
    return {fpc_pkg::OP_ARITH, r, fpc_pkg::OP3_FPOP1, 5'h00, f, s};
  endfunction
  function automatic logic [31:0] mem(input logic [5:0] op3, input logic [4:0] r);
    return {fpc_pkg::OP_MEM, r, op3, 19'h00000};
  endfunction
  initial begin
    void'($urandom(19178));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(fpc_pkg::REG_FSR, rv);
    chk("status reset", rv, fpc_pkg::FSR_RESET);
    chk("freeze reset", {31'h0, freeze}, 32'h0);
    for (i = 0; i < 32; i++) begin
      exp_f[i] = $urandom;
      wr(8'h80 + 8'(i * 4), exp_f[i]);
      rd(8'h80 + 8'(i * 4), rv);
      chk("operand reg", rv, exp_f[i]);
    end
    rd(8'h10, rv);
    chk("unmapped", rv, 32'h0);
    d = $urandom;
    u_iu.fetch(32'h100, mem(fpc_pkg::OP3_LDF, 5'd5));
    u_iu.launch(1'b0, d);
    exp_f[5] = d;
    @(posedge clk);
    rd(8'h94, rv);
    chk("load word", rv, exp_f[5]);
    u_iu.fetch(32'h104, fp_operate_instruction(fpc_pkg::OPF_MOVS, 5'd6, 5'd5));
    u_iu.launch(1'b0, 32'h0);
    exp_f[6] = exp_f[5];
    rd(fpc_pkg::REG_QCTL, rv);
    chk("queue busy", rv, 32'h1);
    repeat (8) @(posedge clk);
    rd(8'h98, rv);
    chk("move result", rv, exp_f[6]);
    u_iu.fetch(32'h108, mem(fpc_pkg::OP3_STF, 5'd6));
    n_oe = 0;
    u_iu.launch(1'b0, 32'h0);
    repeat (2) @(posedge clk);
    chk("store cycles", 32'(n_oe), 32'h1);
    chk("store word", last_st, exp_f[6]);
    u_iu.fetch(32'h200, fp_operate_instruction(9'h1ff, 5'd1, 5'd2));
    u_iu.fetch(32'h204, fp_operate_instruction(fpc_pkg::OPF_MOVS, 5'd3, 5'd4));
    u_iu.launch(1'b1, 32'h0);
    repeat (6) @(posedge clk);
    chk("fault flag", {31'h0, exc}, 32'h1);
    rd(fpc_pkg::REG_FSR, rv);
    chk("trap type", {29'h0, rv[16:14]}, {29'h0, fpc_pkg::FTT_UNIMP});
    rd(fpc_pkg::REG_QADDR, rv);
    chk("fault address", rv, 32'h200);
    rd(fpc_pkg::REG_QINSTR, rv);
    chk("fault word", rv, fp_operate_instruction(9'h1ff, 5'd1, 5'd2));
    for (i = 1; i < 4; i++) begin
      u_iu.fetch(32'h300 + 32'(i * 4), fp_operate_instruction(9'h1ff, 5'(10 + i), 5'(10 + i)));
      u_iu.launch(1'b0, 32'h0);
    end
    rd(fpc_pkg::REG_QCTL, rv);
    chk("queue full", rv, 32'h4);
    u_iu.fetch(32'h400, fp_operate_instruction(fpc_pkg::OPF_MOVS, 5'd7, 5'd6));
    u_iu.launch(1'b0, 32'h0);
    exp_f[7] = exp_f[6];
    #1 chk("freeze on full", {31'h0, freeze}, 32'h1);
    wr(fpc_pkg::REG_QCTL, 32'h1);
    #1 chk("freeze freed", {31'h0, freeze}, 32'h0);
    repeat (10) @(posedge clk);
    rd(8'h9c, rv);
    chk("held move", rv, exp_f[7]);
    chk("fault cleared", {31'h0, exc}, 32'h0);
    u_iu.fetch(32'h500, fp_operate_instruction(fpc_pkg::OPF_NEGS, 5'd8, 5'd7));
    u_iu.launch(1'b0, 32'h0);
    u_iu.fetch(32'h504, fp_operate_instruction(fpc_pkg::OPF_ABSS, 5'd9, 5'd7));
    u_iu.launch(1'b0, 32'h0);
    u_iu.fetch(32'h508, fp_operate_instruction(fpc_pkg::OPF_MOVPR, 5'd10, 5'd6));
    u_iu.launch(1'b0, 32'h0);
    repeat (12) @(posedge clk);
    rd(8'ha0, rv);
    chk("negate", rv, {~exp_f[7][31], exp_f[7][30:0]});
    rd(8'ha4, rv);
    chk("absolute", rv, {1'b0, exp_f[7][30:0]});
    rd(8'ha8, rv);
    chk("pair even", rv, exp_f[6]);
    rd(8'hac, rv);
    chk("pair odd", rv, exp_f[7]);
    test_done();
  end
endmodule
